// file: design/mia_pkg.sv
/*
 * package for the masked interrupt aggregator: register addresses,
 * reset values, source layout, bus request carrier.
 * assumes a simple word-wide cpu register port on one 100 MHz clock.
 */
package mia_pkg;

    localparam int unsigned MIA_NSRC = 32;
    localparam int unsigned MIA_AW = 32;
    localparam int unsigned MIA_DW = 32;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [31:0] MIA_ADDR_RAW_STATUS = 32'h10001000;
    localparam logic [31:0] MIA_ADDR_MASK = 32'h10001004;
    localparam logic [31:0] MIA_ADDR_MASK_SET = 32'h10001008;
    localparam logic [31:0] MIA_ADDR_MASK_CLR = 32'h1000100C;
    localparam logic [31:0] MIA_ADDR_PENDING = 32'h10001010;
    localparam logic [31:0] MIA_ADDR_SW_TRIG = 32'h13016000;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [31:0] MIA_RST_MASK = 32'h0FFFFFFF;
    localparam logic [31:0] MIA_RST_ZERO = 32'h00000000;
    localparam logic MIA_RST_SW_BIT = 1'b1;
    localparam int unsigned MIA_SW_SRC_POS = 4;
    localparam int unsigned MIA_SW_TRIG_POS = 0;
    // positions 1..3 carry no source
    localparam logic [31:0] MIA_SRC_PRESENT = 32'hFFFFFFF1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mia_req_t;

    typedef enum logic [2:0] {
        MIA_RD_IDLE = 3'b001,
        MIA_RD_HOLD = 3'b010,
        MIA_RD_BAD = 3'b100
    } mia_rd_state_t;

endpackage : mia_pkg

// file: design/mia_src_sample.sv
/*
 * source sampler: registers the live peripheral request levels and
 * merges the software source; unassigned positions forced to 0.
 * assumes request lines are synchronous to i_clk_sys.
 */
`timescale 1ns/100ps
module mia_src_sample import mia_pkg::*; #(
    parameter int unsigned NSRC = MIA_NSRC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [NSRC-1:0] i_src_req,
    input wire logic i_sw_active,
    output logic [NSRC-1:0] o_status
);
    logic [NSRC-1:0] status_reg;
    wire logic [NSRC-1:0] merged;
    wire logic [NSRC-1:0] sw_vec;

    assign sw_vec = NSRC'(i_sw_active) << MIA_SW_SRC_POS;
    // levels are followed, never latched: drops when request drops
    assign merged = (i_src_req | sw_vec) & MIA_SRC_PRESENT[NSRC-1:0]; // RULE15 RULE14

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            status_reg <= '0; // RULE4
        end else begin
            status_reg <= merged; // RULE2
        end
    end

    assign o_status = status_reg;
endmodule : mia_src_sample

// file: design/mia_mask_reg.sv
/*
 * mask register with direct, set and clear write paths.
 * assumes at most one write strobe per cycle from the decoder.
 */
`timescale 1ns/100ps
module mia_mask_reg import mia_pkg::*; #(
    parameter int unsigned NSRC = MIA_NSRC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_wr_direct,
    input wire logic i_wr_set,
    input wire logic i_wr_clr,
    input wire logic [NSRC-1:0] i_wdata,
    output logic [NSRC-1:0] o_mask
);
    logic [NSRC-1:0] mask_reg;
    wire logic [NSRC-1:0] mask_next;

    // all bits are plain storage, source or not
    assign mask_next = i_wr_direct ? i_wdata : // RULE5 RULE13
                       i_wr_set ? (mask_reg | i_wdata) : // RULE6
                       i_wr_clr ? (mask_reg & ~i_wdata) : // RULE7
                       mask_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            mask_reg <= MIA_RST_MASK[NSRC-1:0]; // RULE4
        end else begin
            mask_reg <= mask_next;
        end
    end

    assign o_mask = mask_reg;
endmodule : mia_mask_reg

// file: design/mia_top.sv
/*
 * masked interrupt aggregator top: cpu register port, pending logic,
 * processor request and wake-up outputs, software trigger bit.
 * assumes a single-cycle cpu register port (wr/rd strobe with address);
 * read data appears one cycle after the read strobe.
 */
// Notes on behaviour
// RULE1 - thirty-two sources, one bit each
// RULE2 - raw status shows live request, ignores mask
// RULE3 - mask one blocks source, zero passes
// RULE4 - reset: mask per table, status pending zero
// RULE5 - mask written direct, by set, by clear
// RULE6 - set port ones set mask bits
// RULE7 - clear port ones clear mask bits
// RULE8 - pending equals status and not mask
// RULE9 - masked sources never request or pend
// RULE10 - unmasked active source raises wake-up
// RULE11 - software bit: zero raises, one withdraws
// RULE12 - software interrupt held until one written
// RULE13 - unassigned mask bits are plain storage
// RULE14 - unassigned status, pending bits read zero
// RULE15 - status follows live peripheral levels
// RULE16 - handler clears peripheral, waits pending drop
// RULE17 - processor request is OR of pending
// RULE18 - read-only writes ignored, write-only reads zero
`timescale 1ns/100ps
module mia_top import mia_pkg::*; #(
    parameter int unsigned NSRC = MIA_NSRC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [NSRC-1:0] i_src_req,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [MIA_AW-1:0] i_bus_addr,
    input wire logic [MIA_DW-1:0] i_bus_wdata,
    output logic [MIA_DW-1:0] o_bus_rdata,
    output logic o_bus_rvalid,
    output logic o_bus_err,
    output logic o_cpu_irq,
    output logic o_wakeup
);

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    wire mia_req_t req;
    assign req = '{wr: i_bus_wr, rd: i_bus_rd, addr: i_bus_addr,
                   wdata: i_bus_wdata};

    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    wire logic sel_raw;
    wire logic sel_mask;
    wire logic sel_set;
    wire logic sel_clr;
    wire logic sel_pend;
    wire logic sel_sw;
    wire logic sel_any;
    assign sel_raw = hit(req.addr, MIA_ADDR_RAW_STATUS);
    assign sel_mask = hit(req.addr, MIA_ADDR_MASK);
    assign sel_set = hit(req.addr, MIA_ADDR_MASK_SET);
    assign sel_clr = hit(req.addr, MIA_ADDR_MASK_CLR);
    assign sel_pend = hit(req.addr, MIA_ADDR_PENDING);
    assign sel_sw = hit(req.addr, MIA_ADDR_SW_TRIG);
    assign sel_any = sel_raw | sel_mask | sel_set | sel_clr | sel_pend |
                     sel_sw;

    // writes to raw status and pending decode to nothing
    wire logic wr_mask;
    wire logic wr_set;
    wire logic wr_clr;
    wire logic wr_sw;
    assign wr_mask = req.wr & sel_mask;
    assign wr_set = req.wr & sel_set;
    assign wr_clr = req.wr & sel_clr;
    assign wr_sw = req.wr & sel_sw; // RULE18

    // ------------------------------------------------------------
    // software trigger bit
    // ------------------------------------------------------------
    logic sw_trig_reg;
    wire logic sw_trig_next;
    // level held until software writes one; no hardware clear path
    assign sw_trig_next = wr_sw ? req.wdata[MIA_SW_TRIG_POS] // RULE11
                                : sw_trig_reg; // RULE12

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sw_trig_reg <= MIA_RST_SW_BIT; // RULE11
        end else begin
            sw_trig_reg <= sw_trig_next;
        end
    end

    // ------------------------------------------------------------
    // status, mask, pending
    // ------------------------------------------------------------
    logic [NSRC-1:0] status;
    logic [NSRC-1:0] mask;

    mia_src_sample #(.NSRC(NSRC)) u_src (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_src_req(i_src_req), // RULE1
        .i_sw_active(~sw_trig_reg),
        .o_status(status)
    );

    mia_mask_reg #(.NSRC(NSRC)) u_mask (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_wr_direct(wr_mask),
        .i_wr_set(wr_set),
        .i_wr_clr(wr_clr),
        .i_wdata(req.wdata[NSRC-1:0]),
        .o_mask(mask)
    );

    wire logic [NSRC-1:0] pending;
    assign pending = status & ~mask; // RULE8 RULE3 RULE9

    // ------------------------------------------------------------
    // processor request and wake-up
    // ------------------------------------------------------------
    // one cycle behind pending; trades a cycle for a clean flop output
    logic irq_reg;
    logic wake_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg <= |pending; // RULE17 RULE9
            wake_reg <= |pending; // RULE10
        end
    end
    assign o_cpu_irq = irq_reg;
    assign o_wakeup = wake_reg;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire logic [MIA_DW-1:0] rd_mux;
    wire logic [MIA_DW-1:0] sw_word;
    assign sw_word = MIA_DW'(sw_trig_reg) << MIA_SW_TRIG_POS;
    // set and clear ports fall to the zero default
    assign rd_mux = sel_raw ? MIA_DW'(status) :
                    sel_mask ? MIA_DW'(mask) :
                    sel_pend ? MIA_DW'(pending) :
                    sel_sw ? sw_word :
                    MIA_RST_ZERO; // RULE18

    mia_rd_state_t rd_state_next;
    logic [MIA_DW-1:0] rdata_reg;
    logic rvalid_reg;
    logic err_reg;
    wire logic rvalid_next;
    wire logic err_next;

    always_comb begin
        rd_state_next = MIA_RD_IDLE;
        if (req.rd) begin
            rd_state_next = sel_any ? MIA_RD_HOLD : MIA_RD_BAD;
        end
    end

    // unmapped reads return zero with an error flag
    // valid and error decoded ahead so both leave straight from flops
    assign rvalid_next = (rd_state_next != MIA_RD_IDLE);
    assign err_next = (rd_state_next == MIA_RD_BAD); // RULE18

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rdata_reg <= MIA_RST_ZERO;
            rvalid_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            rdata_reg <= req.rd ? rd_mux : MIA_RST_ZERO;
            rvalid_reg <= rvalid_next;
            err_reg <= err_next;
        end
    end

    assign o_bus_rdata = rdata_reg;
    assign o_bus_rvalid = rvalid_reg;
    assign o_bus_err = err_reg;

endmodule : mia_top

// file: test/mia_top_props.sv
/* port checker for mia_top, bound to every instance.
   assumes one-cycle read latency and a two-cycle source path. */
`timescale 1ns/100ps
module mia_top_props import mia_pkg::*; #(
    parameter int unsigned NSRC = MIA_NSRC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [NSRC-1:0] i_src_req,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [31:0] i_bus_addr,
    input wire logic [31:0] i_bus_wdata,
    input wire logic [31:0] o_bus_rdata,
    input wire logic o_bus_rvalid,
    input wire logic o_bus_err,
    input wire logic o_cpu_irq,
    input wire logic o_wakeup
);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);
    wire logic [31:0] a = i_bus_addr;
    wire logic rm = i_bus_rd && a == MIA_ADDR_MASK;
    wire logic rp = i_bus_rd && a == MIA_ADDR_PENDING;
    wire logic rs = i_bus_rd && a == MIA_ADDR_RAW_STATUS;
    wire logic wm = i_bus_wr && a == MIA_ADDR_MASK;
    wire logic ws = i_bus_wr && a == MIA_ADDR_MASK_SET;
    wire logic wc = i_bus_wr && a == MIA_ADDR_MASK_CLR;
    property p_wake; rp |=> o_wakeup == |o_bus_rdata; endproperty
    a_wake: assert property (p_wake) else $error("wake differs");
    property p_err; o_bus_err |-> o_bus_rvalid && o_bus_rdata == 0;
    endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_raw; rs && !$past(i_srst) |=> (o_bus_rdata & 32'hFFFFFFEF)
        == ($past(i_src_req, 2) & 32'hFFFFFFE1); endproperty
    a_raw: assert property (p_raw) else $error("bad status");
    property p_irq; rp |=> o_cpu_irq == |o_bus_rdata; endproperty
    a_irq: assert property (p_irq) else $error("irq vs pend");
    property p_set; ws ##1 rm |=> (o_bus_rdata & $past(i_bus_wdata, 2))
        == $past(i_bus_wdata, 2); endproperty
    a_set: assert property (p_set) else $error("set lost");
    property p_clr; wc ##1 rm |=> (o_bus_rdata & $past(i_bus_wdata, 2))
        == 0; endproperty
    a_clr: assert property (p_clr) else $error("clear lost");
    property p_dir; wm ##1 rm |=> o_bus_rdata == $past(i_bus_wdata, 2);
    endproperty
    a_dir: assert property (p_dir) else $error("mask write");
    property p_rst; $fell(i_srst) |-> !o_cpu_irq && !o_wakeup; endproperty
    a_rst: assert property (p_rst) else $error("irq at reset");
endmodule : mia_top_props
bind mia_top mia_top_props #(.NSRC(NSRC)) u_props (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .i_src_req(i_src_req), .i_bus_wr(i_bus_wr),
    .i_bus_rd(i_bus_rd), .i_bus_addr(i_bus_addr),
    .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
    .o_bus_rvalid(o_bus_rvalid), .o_bus_err(o_bus_err),
    .o_cpu_irq(o_cpu_irq), .o_wakeup(o_wakeup));

// file: test/mia_periph_model.sv
/* peripheral request lines: each level holds until dropped.
   assumes raise and drop strobes from the bench. */
`timescale 1ns/100ps
module mia_periph_model (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [31:0] i_raise,
    input wire logic [31:0] i_drop,
    output logic [31:0] o_req
);
    logic [31:0] req_next;
    assign req_next = (o_req | i_raise) & ~i_drop;
    always_ff @(posedge i_clk_sys) o_req <= i_srst ? 32'h0 : req_next;
endmodule : mia_periph_model

// file: test/test_masked_interrupt_aggregator.sv
/* bench for mia_top: bus tasks, random masks and sources, software
   source, handler flow. assumes one-cycle read latency. */
`timescale 1ns/100ps
module test_masked_interrupt_aggregator import mia_pkg::*; ;
    logic i_clk_sys = 1'h0, i_srst = 1'h1, bw = 1'h0, br = 1'h0;
    logic [31:0] ad = 32'h0, wd = 32'h0, up = 32'h0, dn = 32'h0;
    logic [31:0] src, rdat, m, r, p;
    logic rv, er, irq, wk;
    int err_count = 0, checks = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    mia_periph_model u_per (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_raise(up), .i_drop(dn), .o_req(src));
    mia_top uut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_src_req(src),
        .i_bus_wr(bw), .i_bus_rd(br), .i_bus_addr(ad), .i_bus_wdata(wd),
        .o_bus_rdata(rdat), .o_bus_rvalid(rv), .o_bus_err(er),
        .o_cpu_irq(irq), .o_wakeup(wk));
    task automatic chk(logic [31:0] g, logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic drv(logic w, logic rr, logic [31:0] a, logic [31:0] d);
        @(negedge i_clk_sys);
        bw = w;
        br = rr;
        ad = a;
        wd = d;
    endtask : drv
    function automatic logic mapped(logic [31:0] a);
        return a == MIA_ADDR_RAW_STATUS || a == MIA_ADDR_MASK ||
               a == MIA_ADDR_MASK_SET || a == MIA_ADDR_MASK_CLR ||
               a == MIA_ADDR_PENDING || a == MIA_ADDR_SW_TRIG;
    endfunction : mapped
    task automatic rc(logic [31:0] a, logic [31:0] e);
        drv(1'h0, 1'h1, a, 32'h0);
        drv(1'h0, 1'h0, a, 32'h0);
        chk(rv, 1'h1);
        chk(er, !mapped(a));
        chk(rdat, e);
    endtask : rc
    task automatic wr(logic [31:0] a, logic [31:0] d);
        drv(1'h1, 1'h0, a, d);
        drv(1'h0, 1'h0, a, 32'h0);
    endtask : wr
    // settle time covers model, status and irq flops
    task automatic per(logic [31:0] u, logic [31:0] d);
        @(negedge i_clk_sys);
        up = u;
        dn = d;
        @(negedge i_clk_sys);
        up = 32'h0;
        dn = 32'h0;
        repeat (3) @(negedge i_clk_sys);
    endtask : per
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(32'h042FAC18));
        repeat (8) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_srst = 1'h0;
        chk(irq, 1'h0);
        chk(wk, 1'h0);
        chk(rv, 1'h0);
        rc(MIA_ADDR_RAW_STATUS, 32'h0);
        rc(MIA_ADDR_MASK, 32'h0FFFFFFF);
        rc(MIA_ADDR_PENDING, 32'h0);
        rc(MIA_ADDR_SW_TRIG, 32'h1);
        $display("reset test done");
        m = $urandom();
        drv(1'h1, 1'h0, MIA_ADDR_MASK, m);
        rc(MIA_ADDR_MASK, m);
        r = $urandom();
        drv(1'h1, 1'h0, MIA_ADDR_MASK_SET, r);
        rc(MIA_ADDR_MASK, m | r);
        p = m | r;
        m = $urandom();
        drv(1'h1, 1'h0, MIA_ADDR_MASK_CLR, m);
        rc(MIA_ADDR_MASK, p & ~m);
        rc(MIA_ADDR_MASK_SET, 32'h0);
        rc(MIA_ADDR_MASK_CLR, 32'h0);
        wr(MIA_ADDR_PENDING, 32'hFFFFFFFF);
        drv(1'h1, 1'h0, MIA_ADDR_RAW_STATUS, 32'hFFFFFFFF);
        rc(MIA_ADDR_RAW_STATUS, 32'h0);
        rc(MIA_ADDR_MASK, p & ~m);
        rc(32'h10001014, 32'h0);
        chk(er, 1'h1);
        $display("mask test done");
        for (int i = 0; i < 12; i++) begin
            m = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom();
            r = $urandom();
            wr(MIA_ADDR_MASK, m);
            per(r, ~r);
            p = r & MIA_SRC_PRESENT & ~m;
            rc(MIA_ADDR_RAW_STATUS, r & MIA_SRC_PRESENT);
            rc(MIA_ADDR_PENDING, p);
            chk(irq, |p);
            chk(wk, |p);
        end
        $display("source test done");
        wr(MIA_ADDR_MASK, 32'hFFFFFFEF);
        per(32'h0, 32'hFFFFFFFF);
        drv(1'h1, 1'h0, MIA_ADDR_SW_TRIG, 32'h0);
        rc(MIA_ADDR_SW_TRIG, 32'h0);
        repeat (30) @(negedge i_clk_sys);
        rc(MIA_ADDR_PENDING, 32'h10);
        chk(irq, 1'h1);
        wr(MIA_ADDR_SW_TRIG, 32'h1);
        per(32'h100, 32'h0);
        rc(MIA_ADDR_PENDING, 32'h0);
        wr(MIA_ADDR_MASK_CLR, 32'h100);
        repeat (3) @(negedge i_clk_sys);
        chk(irq, 1'h1);
        wr(MIA_ADDR_MASK_SET, 32'h100);
        per(32'h0, 32'h100);
        rc(MIA_ADDR_PENDING, 32'h0);
        wr(MIA_ADDR_MASK_CLR, 32'h100);
        repeat (3) @(negedge i_clk_sys);
        chk(irq, 1'h0);
        $display("handler test done");
        end_of_test();
    end
endmodule : test_masked_interrupt_aggregator
